// ==== logic/ivrm_pkg.sv ====
// constants and types shared by the virtual register mailbox slave
// What this block does
// [RQ1] answer slave address 0x49: byte 0x92 to write, 0x93 to read
// [RQ2] work with a serial clock of 100 kHz and of 400 kHz
// [RQ3] only three physical registers carry all virtual register traffic
// [RQ4] read-only status at 0x00: bit 1 inbound occupied, bit 0 outbound available
// [RQ5] inbound flag is 1 while a byte is unconsumed; master must not write then
// [RQ6] outbound flag is 1 while a byte waits in the read mailbox, else 0
// [RQ7] write-only mailbox at 0x01 takes virtual addresses and write data
// [RQ8] reading the mailbox at 0x02 returns the pending result byte
// [RQ9] address bit 7 set means write data follows, clear means read request
// [RQ10] master writes: poll flag clear, send address with bit 7, poll, send data
// [RQ11] inbound flag clears once the address byte has been taken in
// [RQ12] master reads: poll flag clear, send address, poll outbound flag, read
// [RQ13] outbound flag sets once the requested value sits in the read mailbox
// [RQ14] multi-byte virtual registers are big-endian, high byte at low address
// [RQ15] master walks multi-byte registers in ascending address order
// [RQ16] 4-byte float registers: sign, 8-bit exponent biased 127, 23-bit fraction
// [RQ17] access is address, pointer, one data byte, or repeated start and one read; code also takes more data bytes and, on a master ack, more reads
package ivrm_pkg;
  // ==========================================================
  // bus address and physical register map
  localparam logic [6:0] SLAVE_ADDR = 7'h49;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WR_MBOX = 8'h01;
  localparam logic [7:0] REG_RD_MBOX = 8'h02;
  localparam int STAT_OCC_BIT = 1;
  localparam int STAT_AVAIL_BIT = 0;
  localparam int VADDR_WRITE_BIT = 7;
  localparam logic [7:0] RESET_PTR = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ==========================================================
  // kind tag carried with each inbound byte
  localparam logic [1:0] KIND_VREAD = 2'h0;
  localparam logic [1:0] KIND_VWRITE = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam int IN_W = 10;
  // ==========================================================
  // float layout of 4-byte virtual registers, high byte first
  localparam int FP_SIGN_POS = 31; // RQ16
  localparam int FP_EXP_LSB = 23;
  localparam int FP_EXP_BIAS = 127;
  localparam int FP_FRAC_W = 23;
  // ==========================================================
  // timing: sync latency must stay inside the data setup window
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SU_DAT_NS = 100;
  localparam int SU_DAT_CYC = T_SU_DAT_NS / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK = 3'b100,
    ST_SEND = 3'b101,
    ST_MACK = 3'b110
  } ivrm_state_t;
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR = 2'b01,
    PH_DATA = 2'b10
  } ivrm_phase_t;
endpackage

// ==== logic/ivrm_stream_if.sv ====
// valid/ready byte stream between the slave core and its buffer
interface ivrm_stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== logic/ivrm_sync.sv ====
// two-flop synchroniser for the bus pins
module ivrm_sync #(
  parameter int W = 2
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] din, // asynchronous pins
  output logic [W-1:0] dout // synchronised copy
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  // idle bus is high, so reset to ones to avoid a false start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule

// ==== logic/ivrm_buf.sv ====
// two-entry buffer: head feeds the consumer, tail catches a word during a stall
module ivrm_buf (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  ivrm_stream_if.snk fill, // words in from the slave core
  ivrm_stream_if.src drain // words out to the consumer
);
  localparam int W = $bits(fill.data);
  logic [W-1:0] head_ff;
  logic [W-1:0] tail_ff;
  logic head_v_ff;
  logic tail_v_ff;
  wire push = fill.valid & ~tail_v_ff;
  wire pop = head_v_ff & drain.ready;
  assign fill.ready = ~tail_v_ff;
  assign drain.valid = head_v_ff;
  assign drain.data = head_ff;
  // head refills from tail on a pop, so word order is kept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      head_ff <= '0;
      tail_ff <= '0;
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
    end else if (pop && tail_v_ff) begin
      head_ff <= tail_ff;
      tail_v_ff <= push;
      if (push) tail_ff <= fill.data;
    end else if (pop || !head_v_ff) begin
      head_v_ff <= push;
      if (push) head_ff <= fill.data;
    end else if (push) begin
      tail_ff <= fill.data;
      tail_v_ff <= 1'b1;
    end
  end
endmodule

// ==== logic/ivrm_top.sv ====
// slave front end: three physical registers bridging virtual register traffic
module ivrm_top
  import ivrm_pkg::*;
(
  input wire logic clock, // 200 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe_n, // low while pulling data low
  output logic in_valid, // inbound byte waiting for the core
  output logic [1:0] in_kind, // read address, write address or data
  output logic [7:0] in_byte, // inbound byte
  input wire logic in_ready, // core takes the inbound byte
  input wire logic out_valid, // core offers a result byte
  input wire logic [7:0] out_byte, // result byte
  output logic out_ready // read mailbox is empty
);
  // ==========================================================
  // pin synchronisation and bus condition detection
  logic [1:0] pins_s;
  logic scl_d_ff;
  logic sda_d_ff;
  ivrm_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({scl_in, sda_in}),
    .dout(pins_s)
  );
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  // edges are taken between synchronised samples only; fine at 400 kHz and below
  wire scl_rise = scl_s & ~scl_d_ff; // RQ2
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  // ==========================================================
  // inbound mailbox path through the two-entry buffer
  ivrm_stream_if #(.W(IN_W)) push_if ();
  ivrm_stream_if #(.W(IN_W)) pop_if ();
  ivrm_buf u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .fill(push_if.snk),
    .drain(pop_if.src)
  );
  assign in_valid = pop_if.valid;
  assign in_kind = pop_if.data[IN_W-1:8];
  assign in_byte = pop_if.data[7:0];
  assign pop_if.ready = in_ready;
  // ==========================================================
  // slave state
  ivrm_state_t state_ff, nxt_state;
  ivrm_phase_t phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic mack_ff;
  logic expect_data_ff;
  logic rd_empty_ff;
  logic [7:0] rd_mbox_ff;
  logic oe_n_ff;
  logic drv_zero_ff;
  // ==========================================================
  // status and register read decode
  // the flag stays set until the core drains every byte, address ones included
  wire occupied = pop_if.valid; // RQ5 RQ11
  wire avail = ~rd_empty_ff; // RQ6
  wire [7:0] status_byte = {6'h00, occupied, avail}; // RQ4
  wire byte_done = scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
  wire addr_match = (shift_ff[7:1] == SLAVE_ADDR); // RQ1
  wire wr_to_mbox = (ptr_ff == REG_WR_MBOX); // RQ7
  wire rd_of_mbox = (ptr_ff == REG_RD_MBOX); // RQ8
  // write-only and unmapped pointers read as zero; only three registers exist
  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] st,
                                          input logic [7:0] mb);
    reg_read = 8'h00; // RQ3
    if (p == REG_STATUS) reg_read = st;
    else if (p == REG_RD_MBOX) reg_read = mb;
  endfunction
  wire [7:0] load_val = reg_read(ptr_ff, status_byte, rd_mbox_ff);
  // bit 7 of a lone address byte says whether a data byte follows
  wire [1:0] push_kind = expect_data_ff ? KIND_DATA :
                         shift_ff[VADDR_WRITE_BIT] ? KIND_VWRITE : KIND_VREAD; // RQ9
  // a byte arriving while the buffer is full is refused with a nack
  wire push = (state_ff == ST_WRITE) && byte_done && wr_to_mbox && push_if.ready;
  assign push_if.valid = push;
  assign push_if.data = {push_kind, shift_ff};
  wire accept = (state_ff == ST_ADDR) ? addr_match :
                (state_ff == ST_WRITE) ? (push_if.ready || !wr_to_mbox) : 1'b1;
  wire pop_rd = (state_ff == ST_SEND) && scl_fall && (bit_cnt_ff == 4'h7) && rd_of_mbox
                && !rd_empty_ff; // RQ8
  wire take_out = out_valid && rd_empty_ff; // RQ13
  // ==========================================================
  // next state; start wins over everything, stop releases the bus
  always_comb begin
    nxt_state = state_ff;
    if (start_det) begin
      nxt_state = ST_ADDR; // RQ17
    end else if (stop_det) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: nxt_state = ST_IDLE;
        ST_ADDR, ST_PTR, ST_WRITE: begin
          if (byte_done) nxt_state = accept ? ST_ACK : ST_IDLE;
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (phase_ff == PH_ADDR) nxt_state = rw_ff ? ST_SEND : ST_PTR;
            else nxt_state = ST_WRITE;
          end
        end
        ST_SEND: begin
          if (scl_fall && bit_cnt_ff == 4'h7) nxt_state = ST_MACK;
        end
        ST_MACK: begin
          if (scl_fall) nxt_state = mack_ff ? ST_SEND : ST_IDLE;
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // bit counter, shifter and phase bookkeeping
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff <= RESET_BYTE;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_det || (nxt_state != state_ff)) begin
        bit_cnt_ff <= 4'h0;
      end else if ((state_ff == ST_SEND && scl_fall) ||
                   (state_ff inside {ST_ADDR, ST_PTR, ST_WRITE} && scl_rise)) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (scl_rise) shift_ff <= {shift_ff[6:0], sda_s};
      if (state_ff == ST_MACK && scl_rise) mack_ff <= ~sda_s;
      if (byte_done && state_ff == ST_ADDR) begin
        rw_ff <= shift_ff[0];
        phase_ff <= PH_ADDR;
      end else if (byte_done && state_ff == ST_PTR) begin
        phase_ff <= PH_PTR;
      end else if (byte_done && state_ff == ST_WRITE) begin
        phase_ff <= PH_DATA;
      end
    end
  end
  // ==========================================================
  // pointer and data/address tracking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= RESET_PTR;
      expect_data_ff <= 1'b0;
    end else begin
      if (byte_done && state_ff == ST_PTR) ptr_ff <= shift_ff; // RQ17
      if (push) expect_data_ff <= !expect_data_ff && shift_ff[VADDR_WRITE_BIT]; // RQ9
    end
  end
  // ==========================================================
  // read mailbox; the core sends multi-byte values high byte first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_empty_ff <= 1'b1;
      rd_mbox_ff <= RESET_BYTE;
    end else if (take_out) begin
      rd_empty_ff <= 1'b0; // RQ13 RQ14
      rd_mbox_ff <= out_byte;
    end else if (pop_rd) begin
      rd_empty_ff <= 1'b1; // RQ6
    end
  end
  assign out_ready = rd_empty_ff;
  // ==========================================================
  // transmit shifter and open-drain data drive, changed only after scl falls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff <= RESET_BYTE;
      oe_n_ff <= 1'b1;
      drv_zero_ff <= 1'b0;
    end else begin
      drv_zero_ff <= 1'b0;
      if (start_det || stop_det) begin
        oe_n_ff <= 1'b1;
      end else if (byte_done && state_ff != ST_SEND) begin
        oe_n_ff <= ~accept; // ack by pulling low
      end else if (scl_fall && nxt_state == ST_SEND && state_ff != ST_SEND) begin
        tx_ff <= {load_val[6:0], 1'b0}; // RQ4 RQ8
        oe_n_ff <= load_val[7];
      end else if (scl_fall && state_ff == ST_SEND && bit_cnt_ff != 4'h7) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
        oe_n_ff <= tx_ff[7];
      end else if (scl_fall) begin
        oe_n_ff <= 1'b1; // release for the master's ack bit
      end
    end
  end
  assign sda_out = drv_zero_ff;
  assign sda_oe_n = oe_n_ff;
  // ==========================================================
  // checks
  sequence s_take;
    out_valid && out_ready;
  endsequence
  sequence s_pop;
    pop_rd;
  endsequence
  AST_ADDR_ACK: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
    (state_ff == ST_ADDR && byte_done) |=> (sda_oe_n == !$past(addr_match)))
    else $error("address ack does not follow the slave address match");
  AST_TAKE_SETS_AVAIL: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
    s_take |=> avail && !out_ready)
    else $error("outbound flag not set after the mailbox was filled");
  AST_POP_CLEARS: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
    s_pop |=> !avail && out_ready)
    else $error("outbound flag still set after the mailbox was read");
  AST_PUSH_OCC: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
    push |=> occupied)
    else $error("inbound flag not set after a mailbox write");
  AST_PUSH_ROOM: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
    (state_ff == ST_WRITE && byte_done && wr_to_mbox && !push_if.ready) |=> sda_oe_n)
    else $error("full mailbox write was acknowledged");
  AST_DATA_KIND: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
    (push && shift_ff[VADDR_WRITE_BIT] && !expect_data_ff) |=> expect_data_ff)
    else $error("write address did not arm the data byte");
  // the armed byte goes out as data whatever its bit 7, then the flag drops
  AST_DATA_DISARM: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
    (push && expect_data_ff) |=> !expect_data_ff)
    else $error("data byte did not disarm the write address");
  // bit 7 of status is zero so the line is pulled; tx_ff holds bits 6..0 one place up
  AST_STATUS_LOAD: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
    (scl_fall && state_ff == ST_ACK && nxt_state == ST_SEND && ptr_ff == REG_STATUS) |=>
      !sda_oe_n && (tx_ff[2] == $past(occupied)) && (tx_ff[1] == $past(avail)))
    else $error("status byte does not carry the two flags");
  AST_START_ADDR: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
    start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'h0 && sda_oe_n)
    else $error("start did not restart address reception");
  AST_SYNC_FAST: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
    $changed(sda_oe_n) |-> !scl_s)
    else $error("data line moved while the serial clock was high");
endmodule

// ==== verif/ivrm_host_model.sv ====
// host microcontroller model: bus master doing physical register transfers
module ivrm_host_model
  import ivrm_pkg::*;
(
  input wire logic clock, // timing reference for bit phases
  output logic scl, // serial clock, idles high between frames
  output logic sda_oe_n, // low pulls the data line low
  input wire logic sda_in // resolved data line level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // bit timing: quarter bit in clocks, setup of 20 clocks is 100 ns
  int qtr = 20;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic wait_q();
    repeat (qtr) @(posedge clock);
    #1;
  endtask
  // data moves only while the clock is low, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n = b;
    wait_q();
    scl = 1'b1;
    wait_q();
    r = sda_in;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  // serves as start and repeated start alike
  task automatic start();
    sda_oe_n = 1'b1;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_oe_n = 1'b0;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  task automatic stop();
    sda_oe_n = 1'b0;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_oe_n = 1'b1;
    wait_q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nak);
  endtask
  // ==========================================================
  // physical accesses: address, pointer, one byte each way; phys_read2 reads two
  task automatic phys_write(input logic [6:0] a7, input logic [7:0] ptr,
                            input logic [7:0] d, output logic [2:0] nk);
    start();
    wbyte({a7, 1'b0}, nk[2]);
    wbyte(ptr, nk[1]);
    wbyte(d, nk[0]);
    stop();
  endtask
  task automatic phys_read(input logic [7:0] ptr, output logic [7:0] d);
    logic r;
    start();
    wbyte({SLAVE_ADDR, 1'b0}, r);
    wbyte(ptr, r);
    start();
    wbyte({SLAVE_ADDR, 1'b1}, r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r); // a nack ends the read
    stop();
  endtask
  // two bytes in one read: the master ack asks the slave to send again
  task automatic phys_read2(input logic [7:0] ptr, output logic [7:0] d0,
                            output logic [7:0] d1);
    logic r;
    start();
    wbyte({SLAVE_ADDR, 1'b0}, r);
    wbyte(ptr, r);
    start();
    wbyte({SLAVE_ADDR, 1'b1}, r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d0[i]);
    end
    bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d1[i]);
    end
    bit_io(1'b1, r);
    stop();
  endtask
endmodule

// ==== verif/ivrm_top_tb.sv ====
// self-checking bench for the virtual register mailbox slave
module ivrm_top_tb
  import ivrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, in_ready, out_valid, scl, host_oe_n;
  logic sda_out, sda_oe_n, in_valid, out_ready;
  logic [1:0] in_kind;
  logic [7:0] in_byte, out_byte, rd, rd2;
  logic [2:0] nk;
  logic [31:0] fpv;
  wire sda_line;
  int errors = 0;
  int checks = 0;
  // ==========================================================
  // open-drain data line with pull-up
  assign sda_line = host_oe_n & (sda_oe_n | sda_out);
  ivrm_top i_ivrm_top (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .in_valid(in_valid), .in_kind(in_kind),
    .in_byte(in_byte), .in_ready(in_ready), .out_valid(out_valid),
    .out_byte(out_byte), .out_ready(out_ready));
  ivrm_host_model i_ivrm_host_model (.clock(clock), .scl(scl), .sda_oe_n(host_oe_n),
    .sda_in(sda_line));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic status(input logic [7:0] exp);
    i_ivrm_host_model.phys_read(REG_STATUS, rd);
    chk(rd, exp, "status");
  endtask
  // core side: wait bounded for an inbound byte, check it, take it
  task automatic take_in(input logic [1:0] kind, input logic [7:0] b);
    int k = 0;
    while (in_valid !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    if (in_valid !== 1'b1) begin
      errors++;
      conclude();
    end
    chk({6'h0, in_kind}, {6'h0, kind}, "inbound kind");
    chk(in_byte, b, "inbound byte");
    in_ready = 1'b1;
    tick(1);
    in_ready = 1'b0;
  endtask
  // core side: offer one result byte; the mailbox must close next cycle
  task automatic offer(input logic [7:0] b);
    out_valid = 1'b1;
    out_byte = b;
    tick(1);
    out_valid = 1'b0;
    chk({7'h0, out_ready}, 8'h00, "mailbox closed");
  endtask
  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (98000) @(posedge clock);
    errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    in_ready = 1'b0;
    out_valid = 1'b0;
    out_byte = 8'h00;
    tick(16);
    chk({5'h0, sda_oe_n, in_valid, out_ready}, 8'h05, "reset outputs");
    rst_n = 1'b1;
    tick(4);
    // test 1: idle status at fast-mode bus speed, then faster bulk traffic
    i_ivrm_host_model.qtr = 125;
    status(8'h00);
    i_ivrm_host_model.qtr = 20;
    $display("test 1 done");
    // test 2: foreign address, read-only and write-only places
    i_ivrm_host_model.phys_write(7'h4a, REG_WR_MBOX, 8'h11, nk);
    chk({5'h0, nk}, 8'h07, "foreign address nack");
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_STATUS, 8'hff, nk);
    chk({5'h0, nk}, 8'h00, "status write acks");
    chk({7'h0, in_valid}, 8'h00, "nothing inbound");
    i_ivrm_host_model.phys_read(REG_WR_MBOX, rd);
    chk(rd, 8'h00, "write mailbox reads zero");
    i_ivrm_host_model.phys_read(8'h05, rd);
    chk(rd, 8'h00, "unmapped reads zero");
    $display("test 2 done");
    // test 3: virtual write, data byte with bit 7 set stays data
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h85, nk);
    chk({5'h0, nk}, 8'h00, "address write acks");
    status(8'h02);
    take_in(KIND_VWRITE, 8'h85);
    status(8'h00);
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h9c, nk);
    take_in(KIND_DATA, 8'h9c);
    $display("test 3 done");
    // test 4: stalled core fills both entries, third byte refused
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h12, nk);
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h07, nk);
    chk({5'h0, nk}, 8'h00, "second entry acks");
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h55, nk);
    chk({5'h0, nk}, 8'h01, "full buffer nacks");
    status(8'h02);
    take_in(KIND_VREAD, 8'h12);
    take_in(KIND_VREAD, 8'h07);
    chk({7'h0, in_valid}, 8'h00, "buffer drained");
    $display("test 4 done");
    // test 5: virtual read of a 4-byte float, high byte first
    fpv = {1'b0, 8'(FP_EXP_BIAS - 3), 23'h200000};
    i_ivrm_host_model.phys_write(SLAVE_ADDR, REG_WR_MBOX, 8'h14, nk);
    take_in(KIND_VREAD, 8'h14);
    for (int b = 0; b < 4; b++) begin
      offer(fpv[31 - 8 * b -: 8]);
      status(8'h01);
      // last byte read twice in one transfer: the mailbox pops only once
      if (b == 3) begin
        i_ivrm_host_model.phys_read2(REG_RD_MBOX, rd, rd2);
        chk(rd2, fpv[7:0], "repeated mailbox byte");
      end else begin
        i_ivrm_host_model.phys_read(REG_RD_MBOX, rd);
      end
      chk(rd, fpv[31 - 8 * b -: 8], "float byte");
      chk({7'h0, out_ready}, 8'h01, "mailbox reopens");
    end
    status(8'h00);
    $display("test 5 done");
    conclude();
  end
endmodule
